/* logic/comparator_control_pkg.sv */
// How it works
// - wake flag needs enable_n low, fresh read, sleep, output change
// - a control register read latches the output as wake reference
// - wake flag holds through other_reset until software clears it or a power-on reset
// - output bit 7 is read-only; writes to it are ignored
// - comparator output also feeds the timer clock mux internally
// - an enabled comparator keeps running through sleep
// - power-on reset loads all ones into the seven stored control fields
// - comparator held powered down while reset is asserted
// - a change seen asleep with wake enabled wakes via reset path
// - control register at 07h holds eight fields, bit 7 output
// - status at 03h: pin wake bit 7, comparator wake bit 6, bit 5 zero
// - raw result high when noninverting input exceeds inverting input
// - polarity, pin, timer, wake bits act only when enabled; reference bits always pass
// - polarity one passes output uninverted, zero inverts it
// - timer select zero routes comparator output as timer clock
`default_nettype none
package comparator_control_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [4:0] STATUS_ADDR = 5'h03;
    localparam logic [4:0] CONTROL_ADDR = 5'h07;
    localparam logic [7:0] CONTROL_RESET = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // settling wait in clocks before the output bit is trusted; plain default
    localparam int SETTLE_CYCLES = 4;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_OUTPUT = 7;
    localparam int BIT_PIN_EN_N = 6;
    localparam int BIT_POLARITY = 5;
    localparam int BIT_TIMER_SEL = 4;
    localparam int BIT_ENABLE = 3;
    localparam int BIT_NEG_REF = 2;
    localparam int BIT_POS_REF = 1;
    localparam int BIT_WAKE_EN_N = 0;
    localparam int BIT_PIN_WAKE = 7;
    localparam int BIT_CMP_WAKE = 6;
endpackage
`default_nettype wire

/* logic/comparator_control_wakeup.sv */
`timescale 1ns/1ps
`default_nettype none
module comparator_control_wakeup (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic other_reset,
    input wire logic pin_wake_event,
    input wire logic [4:0] reg_addr,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic analog_result,
    input wire logic sleep_active,
    output logic comparator_power_on,
    output logic negative_ref_select,
    output logic positive_ref_select,
    output logic comparator_pin_drive,
    output logic comparator_pin_oe_n,
    output logic timer_clock_from_comparator,
    output logic timer_clock_source,
    output logic comparator_wake_req
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [6:0] ctrl;
        logic out_sync;
        logic ref_val;
        logic armed;
        logic cmp_wake;
        logic pin_wake;
        logic wake_req;
        logic [7:0] rdata;
    } state_type;
    state_type state_reg;
    state_type state_next;
    logic enabled;
    logic out_bit;
    logic changed;
    logic ctrl_wr;
    logic ctrl_rd;
    logic stat_wr;
    logic wake_set;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    // decoded strobes and qualified output
    assign enabled = state_reg.ctrl[comparator_control_pkg::BIT_ENABLE];
    // polarity only acts while enabled; a disabled core reads as zero
    assign out_bit = state_reg.out_sync ^ (enabled &
        ~state_reg.ctrl[comparator_control_pkg::BIT_POLARITY]);
    assign ctrl_wr = reg_write &&
        reg_addr == comparator_control_pkg::CONTROL_ADDR;
    assign ctrl_rd = reg_read &&
        reg_addr == comparator_control_pkg::CONTROL_ADDR;
    assign stat_wr = reg_write &&
        reg_addr == comparator_control_pkg::STATUS_ADDR;
    assign changed = sleep_active && state_reg.armed &&
        (out_bit != state_reg.ref_val);
    // a change only counts while enabled and with the active-low enable clear
    assign wake_set = changed && enabled &&
        !state_reg.ctrl[comparator_control_pkg::BIT_WAKE_EN_N];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    // next-state logic; later branches override earlier ones on purpose
    always_comb begin
        state_next = state_reg;
        state_next.wake_req = 1'b0;
        // one flop on the raw result keeps the change compare glitch free
        state_next.out_sync = analog_result & enabled;
        if (other_reset) begin
            state_next.armed = 1'b0;
        end
        if (ctrl_wr) begin
            // bit 7 is not stored: writes to it vanish
            state_next.ctrl = reg_wdata[6:0];
            state_next.armed = 1'b0;
        end
        if (ctrl_rd) begin
            state_next.ref_val = out_bit;
            state_next.armed = 1'b1;
        end
        if (stat_wr) begin
            state_next.cmp_wake =
                reg_wdata[comparator_control_pkg::BIT_CMP_WAKE];
            state_next.pin_wake =
                reg_wdata[comparator_control_pkg::BIT_PIN_WAKE];
        end
        if (pin_wake_event) begin
            state_next.pin_wake = 1'b1;
        end
        // set wins over a same-cycle clear
        if (wake_set) begin
            state_next.cmp_wake = 1'b1;
            state_next.wake_req = 1'b1;
            state_next.armed = 1'b0;
        end
        state_next.rdata = 8'h00;
        if (reg_addr == comparator_control_pkg::CONTROL_ADDR) begin
            state_next.rdata = {out_bit, state_reg.ctrl};
        end else if (reg_addr == comparator_control_pkg::STATUS_ADDR) begin
            state_next.rdata = {state_reg.pin_wake, state_reg.cmp_wake,
                6'h00};
        end
    end

    // power-on reset only; other resets go through other_reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            // bit 7 is the live output; only the stored fields take the preset
            state_reg.ctrl <=
                comparator_control_pkg::CONTROL_RESET[6:0];
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs to analog core, pin and timer
    // ---------------------------------------------------------------
    assign reg_rdata = state_reg.rdata;
    // runs in sleep too; held off throughout reset
    assign comparator_power_on = reset_n & enabled;
    // reference selects pass straight to the analog input muxes
    assign negative_ref_select =
        state_reg.ctrl[comparator_control_pkg::BIT_NEG_REF];
    assign positive_ref_select =
        state_reg.ctrl[comparator_control_pkg::BIT_POS_REF];
    assign comparator_pin_drive = out_bit;
    assign comparator_pin_oe_n = ~(enabled &
        ~state_reg.ctrl[comparator_control_pkg::BIT_PIN_EN_N]);
    assign timer_clock_from_comparator = enabled &
        ~state_reg.ctrl[comparator_control_pkg::BIT_TIMER_SEL];
    assign timer_clock_source = out_bit;
    assign comparator_wake_req = state_reg.wake_req;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // flag and wake request
    chk_wake_sets: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wake_set |=>
            state_reg.cmp_wake)
        else $error("wake flag not set");
    chk_wake_holds: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg.cmp_wake && !stat_wr) |=>
            state_reg.cmp_wake)
        else $error("wake flag dropped");
    chk_wake_pulse: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ($rose(state_reg.cmp_wake) && !$past(stat_wr)) |->
            comparator_wake_req)
        else $error("no wake request");
    chk_wake_once: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        comparator_wake_req |=>
            !comparator_wake_req)
        else $error("wake request too long");
    chk_no_wake_awake: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !sleep_active |=>
            !comparator_wake_req)
        else $error("wake while awake");

    // arming of the change compare
    chk_ref_latch: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ctrl_rd |=>
            (state_reg.armed && state_reg.ref_val == $past(out_bit)))
        else $error("reference not latched");
    chk_disarm: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ((ctrl_wr || other_reset) && !ctrl_rd) |=>
            !state_reg.armed)
        else $error("compare still armed");
    chk_ctrl_kept: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (other_reset && !ctrl_wr) |=>
            state_reg.ctrl == $past(state_reg.ctrl))
        else $error("control lost on reset");

    // register view
    chk_ctrl_write: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ctrl_wr |=>
            ({1'b0, state_reg.ctrl} == ($past(reg_wdata) & 8'h7F)))
        else $error("control write lost");
    chk_read_output: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        reg_addr == comparator_control_pkg::CONTROL_ADDR |=>
            reg_rdata[7] == $past(out_bit))
        else $error("output bit not shown");
    chk_status_read: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        reg_addr == comparator_control_pkg::STATUS_ADDR |=>
            reg_rdata[5:0] == 6'h00)
        else $error("status low bits not zero");
    chk_pin_flag: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        pin_wake_event |=>
            state_reg.pin_wake)
        else $error("pin wake flag not set");

    // steering and power
    chk_timer_route: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !enabled |->
            (!timer_clock_from_comparator && comparator_pin_oe_n))
        else $error("disabled comparator steering");
    chk_sync_off: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !enabled |=>
            !state_reg.out_sync)
        else $error("disabled output not low");
    chk_polarity: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        enabled |-> out_bit == (state_reg.out_sync ^
            !state_reg.ctrl[comparator_control_pkg::BIT_POLARITY]))
        else $error("polarity wrong");
    // no disable here: this one must hold while reset is low
    chk_power_reset: assert property (
        @(posedge clk_sys)
        !reset_n |->
            !comparator_power_on)
        else $error("powered during reset");
endmodule
`default_nettype wire

/* test/comparator_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// stand-in for the analog core and the cpu sleep control
module comparator_partner (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] level_pos,
    input wire logic [7:0] level_neg,
    input wire logic sleep_enter,
    input wire logic power_on,
    input wire logic wake_req,
    output logic analog_result,
    output logic sleep_active
);
    logic noise_reg;
    // an unpowered core gives no stable answer, so it wobbles
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            noise_reg <= 1'b0;
        end else begin
            noise_reg <= ~noise_reg;
        end
    end
    assign analog_result = power_on ? (level_pos > level_neg) : noise_reg;
    // wake leaves sleep through the reset path
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) sleep_active <= 1'b0;
        else if (wake_req) sleep_active <= 1'b0;
        else if (sleep_enter) sleep_active <= 1'b1;
    end
endmodule
`default_nettype wire

/* test/comparator_control_wakeup_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module comparator_control_wakeup_tb;
    localparam logic [4:0] CTL = comparator_control_pkg::CONTROL_ADDR;
    localparam logic [4:0] STS = comparator_control_pkg::STATUS_ADDR;
    localparam int SETTLE = comparator_control_pkg::SETTLE_CYCLES;
    localparam int SLEEP = 0;
    localparam int OTHER = 1;
    localparam int PINW = 2;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic other_reset = 1'b0;
    logic pin_wake_event = 1'b0;
    logic reg_read = 1'b0;
    logic reg_write = 1'b0;
    logic sleep_enter = 1'b0;
    logic seen = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] level_pos = 8'h80;
    logic [7:0] level_neg = 8'h40;
    logic [7:0] reg_rdata;
    logic analog_result, sleep_active, power_on, pin_drive, pin_oe_n;
    logic timer_cmp, wake_req, neg_sel, pos_sel, timer_src;
    int err_total = 0;
    int samples_checked = 0;
    initial forever #2.5 clk_sys = ~clk_sys;
    comparator_control_wakeup u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .other_reset(other_reset), .pin_wake_event(pin_wake_event),
        .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .analog_result(analog_result), .sleep_active(sleep_active),
        .comparator_power_on(power_on), .negative_ref_select(neg_sel),
        .positive_ref_select(pos_sel), .comparator_pin_drive(pin_drive),
        .comparator_pin_oe_n(pin_oe_n),
        .timer_clock_from_comparator(timer_cmp),
        .timer_clock_source(timer_src), .comparator_wake_req(wake_req));
    comparator_partner u_model (.clk_sys(clk_sys), .reset_n(reset_n),
        .level_pos(level_pos), .level_neg(level_neg),
        .sleep_enter(sleep_enter), .power_on(power_on), .wake_req(wake_req),
        .analog_result(analog_result), .sleep_active(sleep_active));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t bit %b want %b", $time, got, exp);
        end
    endtask
    // one access, strobe held a single cycle
    task automatic access(input logic wr, input logic [4:0] a,
        input logic [7:0] d);
        @(posedge clk_sys);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_read = !wr;
        reg_write = wr;
        @(posedge clk_sys);
        #1 reg_read = 1'b0;
        reg_write = 1'b0;
    endtask
    task automatic read_check(input logic [4:0] a, input logic [7:0] exp);
        access(1'b0, a, 8'h00);
        check_byte(reg_rdata, exp);
    endtask
    // one-cycle pulse on a side input picked by sel
    task automatic pulse(input int sel);
        @(posedge clk_sys);
        #1;
        sleep_enter = (sel == SLEEP);
        other_reset = (sel == OTHER);
        pin_wake_event = (sel == PINW);
        @(posedge clk_sys);
        #1;
        sleep_enter = 1'b0;
        other_reset = 1'b0;
        pin_wake_event = 1'b0;
    endtask
    // bounded watch for the one-cycle wake request
    task automatic watch_wake(input int n);
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            @(posedge clk_sys);
            #1 seen = (wake_req === 1'b1);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        check_bit(power_on, 1'b0);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        read_check(CTL, 8'hFF);
        read_check(STS, 8'h00);
        $display("reset test done");
        access(1'b1, CTL, 8'h00);
        check_bit(power_on, 1'b0);
        read_check(CTL, 8'h00);
        check_bit(timer_cmp, 1'b0);
        check_bit(pin_oe_n, 1'b1);
        access(1'b1, CTL, 8'h28);
        repeat (SETTLE) @(posedge clk_sys);
        read_check(CTL, 8'hA8);
        check_bit(pin_oe_n, 1'b0);
        check_bit(pin_drive, 1'b1);
        check_bit(timer_cmp, 1'b1);
        check_bit(timer_src, 1'b1);
        check_bit(neg_sel, 1'b0);
        check_bit(pos_sel, 1'b0);
        access(1'b1, CTL, 8'hDE);
        repeat (SETTLE) @(posedge clk_sys);
        read_check(CTL, 8'h5E);
        check_bit(pin_drive, 1'b0);
        check_bit(timer_src, 1'b0);
        check_bit(pin_oe_n, 1'b1);
        check_bit(timer_cmp, 1'b0);
        check_bit(neg_sel, 1'b1);
        check_bit(pos_sel, 1'b1);
        $display("control test done");
        access(1'b1, CTL, 8'h28);
        repeat (SETTLE) @(posedge clk_sys);
        read_check(CTL, 8'hA8);
        pulse(SLEEP);
        level_pos = 8'h20;
        check_bit(power_on, 1'b1);
        watch_wake(20);
        check_bit(seen, 1'b1);
        read_check(STS, 8'h40);
        pulse(OTHER);
        read_check(CTL, 8'h28);
        read_check(STS, 8'h40);
        access(1'b1, STS, 8'h3F);
        read_check(STS, 8'h00);
        pulse(PINW);
        read_check(STS, 8'h80);
        $display("wake test done");
        // wake disabled by its enable bit, then by a write since the read
        access(1'b1, CTL, 8'h29);
        repeat (SETTLE) @(posedge clk_sys);
        read_check(CTL, 8'h29);
        pulse(SLEEP);
        level_pos = 8'h80;
        watch_wake(20);
        check_bit(seen, 1'b0);
        read_check(STS, 8'h80);
        access(1'b1, CTL, 8'h28);
        watch_wake(20);
        check_bit(seen, 1'b0);
        $display("arming test done");
        // second power-on reset in mid-run, then switch off before sleep
        @(posedge clk_sys);
        #1 reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        check_bit(power_on, 1'b0);
        #1 reset_n = 1'b1;
        read_check(CTL, 8'hFF);
        read_check(STS, 8'h00);
        access(1'b1, CTL, 8'h20);
        check_bit(power_on, 1'b0);
        pulse(SLEEP);
        level_pos = 8'h20;
        check_bit(power_on, 1'b0);
        watch_wake(20);
        check_bit(seen, 1'b0);
        $display("sleep power test done");
        stop_test();
    end
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
